// ===== mio_cfg.svh
// Constants for the micro I/O, data-memory and clear block
// Contract
// - Data memory is 512 bits: eight files of sixteen four-bit words.
// - Three-bit file select loads a constant or complements its top bit.
// - Word pointer compares, loads constant, increments, decrements, transfers data.
// - Memory written from accumulator or constant; read loads pointer or accumulator.
// - Any single bit of the addressed word can be set, cleared or tested.
// - Input word goes to the adder: tested nonzero or stored in accumulator.
// - Port select low picks scan inputs, high picks auxiliary inputs.
// - Hold-mode pin low gives pass mode, high gives sense mode.
// - Hold-mode low keeps input latches reset; high makes them active.
// - Sense latch sets on high input, clears whenever hold-mode is low, whatever the input.
// - Top scan bit passes direct or divided by 2, 10, 20; clear resets count.
// - Eleven, ten or sixteen output latches addressed by word pointer only.
// - Eight parallel outputs come from a 32-entry user-defined converter.
// - Page-to-chapter transfer copies low two page-buffer bits to chapter buffer.
// - Three-level return stack; long branches allowed at any depth.
// - Clear sets pointer zero, page and buffer F, call latch zero, output latches zero.
// - Processor stays cleared while the external clear pin is high.
// - Cleared parallel register shows converter pattern for code zero.
`ifndef MIO_CFG_SVH
`define MIO_CFG_SVH
`define MIO_FILES 8
`define MIO_WORDS 16
`define MIO_PAGE_RESET 4'hF
`define MIO_PC_RESET 6'h00
`define MIO_DIV_DIRECT 2'h0
`define MIO_DIV_2 2'h1
`define MIO_DIV_10 2'h2
`define MIO_DIV_20 2'h3
`define MIO_STACK_DEPTH 3
`endif

// ===== mio_pkg.sv
// Types for the micro I/O, data-memory and clear block
package mio_pkg;
   typedef enum logic [4:0] {
      MIO_NOP, MIO_LDX, MIO_COMX, MIO_TCY, MIO_YNEC, MIO_IYC, MIO_DYN, MIO_TAY,
      MIO_TMY, MIO_TAM, MIO_TCM, MIO_TMA, MIO_SBIT, MIO_RBIT, MIO_TBIT, MIO_KNEZ,
      MIO_TKA, MIO_SETR, MIO_RSTR, MIO_TDO, MIO_LDP, MIO_TPC, MIO_CALL, MIO_BR,
      MIO_SUBROUTINE_RETURN, MIO_STEP
   } mio_op_t;
   typedef enum logic [1:0] {MIO_RUN, MIO_CLEAR} mio_state_t;
endpackage

// ===== mio_core.sv
// Data memory, input ports, output latches and clear sequencing
`timescale 1ns/1ps
`include "mio_cfg.svh"
module mio_core #(
   parameter int R_COUNT = 11,
   parameter logic [1:0] DIV_OPTION = `MIO_DIV_DIRECT,
   parameter logic [255:0] PLA_TABLE = 256'h0
) (
   input wire logic sys_clk,
   input wire logic rst,
   input wire mio_pkg::mio_op_t op,
   input wire logic [3:0] op_const,
   input wire logic [3:0] acc_in,
   input wire logic status_latch,
   input wire logic clear_pin,
   input wire logic [3:0] scan_in,
   input wire logic [3:0] aux_in,
   input wire logic port_select,
   input wire logic hold_mode_pin,
   output logic [3:0] word_pointer,
   output logic [2:0] file_select,
   output logic [3:0] mem_word,
   output logic [3:0] acc_load,
   output logic acc_load_valid,
   output logic status_out,
   output logic [R_COUNT-1:0] r_out,
   output logic [7:0] par_out,
   output logic [5:0] instruction_pointer,
   output logic [3:0] page_address,
   output logic [3:0] page_buffer,
   output logic [1:0] chapter_buffer,
   output logic call_latch,
   output logic in_clear
);
   import mio_pkg::*;

   ////////////////////////////////////////////////////////////////
   // Pin synchronisers
   logic [3:0] scan_s1, scan_s2, aux_s1, aux_s2;
   logic sel_s1, sel_s2, hold_s1, hold_s2, clr_s1, clr_s2;
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         scan_s1 <= 4'h0; scan_s2 <= 4'h0; aux_s1 <= 4'h0; aux_s2 <= 4'h0;
         sel_s1 <= 1'b0; sel_s2 <= 1'b0; hold_s1 <= 1'b0; hold_s2 <= 1'b0;
         // Clear reads as asserted out of reset so the clear state outlasts rst
         clr_s1 <= 1'b1; clr_s2 <= 1'b1;
      end else begin
         scan_s1 <= scan_in; scan_s2 <= scan_s1;
         aux_s1 <= aux_in; aux_s2 <= aux_s1;
         sel_s1 <= port_select; sel_s2 <= sel_s1;
         hold_s1 <= hold_mode_pin; hold_s2 <= hold_s1;
         clr_s1 <= clear_pin; clr_s2 <= clr_s1;
      end
   end

   ////////////////////////////////////////////////////////////////
   // Clear state: power-up (rst) or external clear pin
   mio_state_t state;
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) state <= MIO_CLEAR;
      else if (clr_s2) state <= MIO_CLEAR;
      else state <= MIO_RUN;
   end
   logic clearing;
   assign clearing = (state == MIO_CLEAR) || clr_s2;

   ////////////////////////////////////////////////////////////////
   // Divider on the top scan bit; counts both rising and falling edges of the input
   logic [4:0] div_cnt;
   logic div_q, scan3_d, divided_input_bit;
   function automatic logic [4:0] div_limit(input logic [1:0] opt);
      case (opt)
         `MIO_DIV_2: div_limit = 5'h01;
         // Both input edges count, so a ratio R toggles after R edges
         `MIO_DIV_10: div_limit = 5'h09;
         `MIO_DIV_20: div_limit = 5'h13;
         default: div_limit = 5'h00;
      endcase
   endfunction
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         div_cnt <= 5'h00; div_q <= 1'b0; scan3_d <= 1'b0;
      end else if (clr_s2) begin
         div_cnt <= 5'h00; div_q <= 1'b0; scan3_d <= scan_s2[3];
      end else begin
         scan3_d <= scan_s2[3];
         if (scan_s2[3] != scan3_d) begin
            if (div_cnt >= div_limit(DIV_OPTION)) begin
               div_cnt <= 5'h00;
               div_q <= ~div_q;
            end else begin
               div_cnt <= div_cnt + 5'h01;
            end
         end
      end
   end
   // Toggle on every input edge count reached: 2 edges per halving
   assign divided_input_bit = (DIV_OPTION == `MIO_DIV_DIRECT) ? scan_s2[3] : div_q;

   ////////////////////////////////////////////////////////////////
   // Auxiliary sense latches
   logic [3:0] sense;
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) sense <= 4'h0;
      else if (!hold_s2) sense <= 4'h0;
      else sense <= sense | aux_s2;
   end
   logic [3:0] in_bus;
   always_comb begin
      if (!sel_s2) in_bus = {divided_input_bit, scan_s2[2:0]};
      else if (hold_s2) in_bus = sense | aux_s2;
      else in_bus = aux_s2;
   end

   ////////////////////////////////////////////////////////////////
   // Data memory and addressing
   logic [3:0] ram [0:`MIO_FILES*`MIO_WORDS-1];
   logic [6:0] ram_addr;
   assign ram_addr = {file_select, word_pointer};
   logic [3:0] rd_word;
   assign rd_word = ram[ram_addr];

   always_ff @(posedge sys_clk) begin
      if (!clearing) begin
         case (op)
            MIO_TAM: ram[ram_addr] <= acc_in;
            MIO_TCM: ram[ram_addr] <= op_const;
            MIO_SBIT: ram[ram_addr] <= rd_word | (4'h1 << op_const[1:0]);
            MIO_RBIT: ram[ram_addr] <= rd_word & ~(4'h1 << op_const[1:0]);
            default: ;
         endcase
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) file_select <= 3'h0;
      else if (!clearing && op == MIO_LDX) file_select <= op_const[2:0];
      else if (!clearing && op == MIO_COMX) file_select <= {~file_select[2], file_select[1:0]};
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) word_pointer <= 4'h0;
      else if (!clearing) begin
         case (op)
            MIO_TCY: word_pointer <= op_const;
            MIO_IYC, MIO_TCM: word_pointer <= word_pointer + 4'h1;
            MIO_DYN: word_pointer <= word_pointer - 4'h1;
            MIO_TAY: word_pointer <= acc_in;
            MIO_TMY: word_pointer <= rd_word;
            default: ;
         endcase
      end
   end

   // input and memory results to the adder path
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         mem_word <= 4'h0; acc_load <= 4'h0; acc_load_valid <= 1'b0; status_out <= 1'b0;
      end else begin
         mem_word <= rd_word;
         acc_load_valid <= !clearing && (op == MIO_TKA || op == MIO_TMA);
         acc_load <= (op == MIO_TKA) ? in_bus : rd_word;
         case (op)
            MIO_KNEZ: status_out <= (in_bus != 4'h0);
            MIO_TBIT: status_out <= rd_word[op_const[1:0]];
            MIO_YNEC: status_out <= (word_pointer != op_const);
            MIO_IYC: status_out <= (word_pointer == 4'hF);
            MIO_DYN: status_out <= (word_pointer != 4'h0);
            default: status_out <= 1'b1;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////
   // Output latches
   // individual latches by word pointer
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) r_out <= '0;
      else if (clearing) r_out <= '0;
      else if (op == MIO_SETR && int'(word_pointer) < R_COUNT) r_out[word_pointer] <= 1'b1;
      else if (op == MIO_RSTR && int'(word_pointer) < R_COUNT) r_out[word_pointer] <= 1'b0;
   end

   logic [4:0] par_code;
   function automatic logic [7:0] pla(input logic [4:0] idx);
      pla = PLA_TABLE[{idx, 3'b000} +: 8];
   endfunction
   // converter output, clear shows code zero pattern
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         // Zero code shows the user pattern, not all zeros
         par_code <= 5'h00; par_out <= PLA_TABLE[7:0];
      end else begin
         if (clearing) par_code <= 5'h00;
         // status latch is top index bit
         else if (op == MIO_TDO) par_code <= {status_latch, acc_in};
         par_out <= pla(clearing ? 5'h00 : par_code);
      end
   end

   ////////////////////////////////////////////////////////////////
   // Page, chapter and return stack
   logic [5:0] ret_pc [0:`MIO_STACK_DEPTH-1];
   logic [3:0] ret_pa [0:`MIO_STACK_DEPTH-1];
   logic [1:0] ret_ch [0:`MIO_STACK_DEPTH-1];
   logic [1:0] chapter_address;
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         instruction_pointer <= `MIO_PC_RESET;
         page_address <= `MIO_PAGE_RESET;
         page_buffer <= `MIO_PAGE_RESET;
         chapter_buffer <= 2'h0;
         chapter_address <= 2'h0;
         call_latch <= 1'b0;
         for (int i = 0; i < `MIO_STACK_DEPTH; i++) begin
            ret_pc[i] <= 6'h00; ret_pa[i] <= 4'h0; ret_ch[i] <= 2'h0;
         end
      end else if (clearing) begin
         instruction_pointer <= `MIO_PC_RESET;
         page_address <= `MIO_PAGE_RESET;
         page_buffer <= `MIO_PAGE_RESET;
         call_latch <= 1'b0;
      end else begin
         case (op)
            MIO_LDP: page_buffer <= op_const;
            MIO_TPC: chapter_buffer <= page_buffer[1:0];
            MIO_BR: begin
               instruction_pointer <= {2'b00, op_const};
               page_address <= page_buffer;
               chapter_address <= chapter_buffer;
            end
            MIO_CALL: begin
               ret_pc[2] <= ret_pc[1]; ret_pa[2] <= ret_pa[1]; ret_ch[2] <= ret_ch[1];
               ret_pc[1] <= ret_pc[0]; ret_pa[1] <= ret_pa[0]; ret_ch[1] <= ret_ch[0];
               ret_pc[0] <= instruction_pointer + 6'h01;
               ret_pa[0] <= page_address;
               ret_ch[0] <= chapter_address;
               call_latch <= 1'b1;
               instruction_pointer <= {2'b00, op_const};
               page_address <= page_buffer;
               chapter_address <= chapter_buffer;
            end
            MIO_SUBROUTINE_RETURN: begin
               instruction_pointer <= ret_pc[0];
               page_address <= ret_pa[0];
               page_buffer <= ret_pa[0];
               chapter_address <= ret_ch[0];
               chapter_buffer <= ret_ch[0];
               ret_pc[0] <= ret_pc[1]; ret_pa[0] <= ret_pa[1]; ret_ch[0] <= ret_ch[1];
               ret_pc[1] <= ret_pc[2]; ret_pa[1] <= ret_pa[2]; ret_ch[1] <= ret_ch[2];
               call_latch <= 1'b0;
            end
            MIO_STEP: instruction_pointer <= instruction_pointer + 6'h01;
            default: ;
         endcase
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) in_clear <= 1'b1;
      else in_clear <= clearing;
   end

   ////////////////////////////////////////////////////////////////
   // Checks
   a_clear_pointer: assert property (@(posedge sys_clk) disable iff (rst)
      clr_s2 |=> (instruction_pointer == 6'h00 && page_address == 4'hF))
      else $error("clear did not preset pointer and page");
   a_clear_outputs: assert property (@(posedge sys_clk) disable iff (rst)
      clr_s2 |=> (r_out == '0))
      else $error("output latches not cleared under clear pin");
   a_pass_latch: assert property (@(posedge sys_clk) disable iff (rst)
      !hold_s2 |=> (sense == 4'h0))
      else $error("sense latch not reset in pass mode");
   a_sense_hold: assert property (@(posedge sys_clk) disable iff (rst)
      (hold_s2 && $past(hold_s2) && sense[0]) |-> $past(sense[0]) || $past(aux_s2[0]))
      else $error("sense latch set without cause");
   a_tpc_copy: assert property (@(posedge sys_clk) disable iff (rst)
      (!clearing && op == MIO_TPC) |=> chapter_buffer == $past(page_buffer[1:0]))
      else $error("page to chapter transfer wrong");
   a_setr_bit: assert property (@(posedge sys_clk) disable iff (rst)
      (!clearing && op == MIO_SETR && word_pointer == 4'h0) |=> r_out[0])
      else $error("addressed output latch not set");
   a_tcy_load: assert property (@(posedge sys_clk) disable iff (rst)
      (!clearing && op == MIO_TCY) |=> word_pointer == $past(op_const))
      else $error("word pointer constant load failed");
   a_comx_flip: assert property (@(posedge sys_clk) disable iff (rst)
      (!clearing && op == MIO_COMX) |=> file_select[2] != $past(file_select[2]))
      else $error("file select complement failed");
   a_div_clear: assert property (@(posedge sys_clk) disable iff (rst)
      clr_s2 |=> div_cnt == 5'h00)
      else $error("divider count not cleared");
   a_par_clear: assert property (@(posedge sys_clk) disable iff (rst)
      clearing |=> par_out == PLA_TABLE[7:0])
      else $error("parallel outputs not at code zero pattern while clearing");
   a_clear_hold: assert property (@(posedge sys_clk) disable iff (rst)
      clearing |=> $stable(word_pointer))
      else $error("word pointer changed while clearing");
   a_rstr_bit: assert property (@(posedge sys_clk) disable iff (rst)
      (!clearing && op == MIO_RSTR && word_pointer == 4'h0) |=> !r_out[0])
      else $error("addressed output latch not reset");
   a_setr_range: assert property (@(posedge sys_clk) disable iff (rst)
      (!clearing && (op == MIO_SETR || op == MIO_RSTR) && int'(word_pointer) >= R_COUNT)
      |=> $stable(r_out))
      else $error("output latch changed by out of range pointer");
   a_ldx_load: assert property (@(posedge sys_clk) disable iff (rst)
      (!clearing && op == MIO_LDX) |=> file_select == $past(op_const[2:0]))
      else $error("file select constant load failed");
   a_tam_write: assert property (@(posedge sys_clk) disable iff (rst)
      (!clearing && op == MIO_TAM) |=> ram[$past(ram_addr)] == $past(acc_in))
      else $error("accumulator not written to memory");
   a_tcm_write: assert property (@(posedge sys_clk) disable iff (rst)
      (!clearing && op == MIO_TCM) |=> ram[$past(ram_addr)] == $past(op_const))
      else $error("constant not written to memory");
   a_sbit_set: assert property (@(posedge sys_clk) disable iff (rst)
      (!clearing && op == MIO_SBIT) |=> ram[$past(ram_addr)][$past(op_const[1:0])])
      else $error("memory bit not set");
   a_rbit_clear: assert property (@(posedge sys_clk) disable iff (rst)
      (!clearing && op == MIO_RBIT) |=> !ram[$past(ram_addr)][$past(op_const[1:0])])
      else $error("memory bit not reset");
   a_iyc_step: assert property (@(posedge sys_clk) disable iff (rst)
      (!clearing && op == MIO_IYC) |=> word_pointer == $past(word_pointer) + 4'h1)
      else $error("word pointer increment failed");
   a_dyn_step: assert property (@(posedge sys_clk) disable iff (rst)
      (!clearing && op == MIO_DYN) |=> word_pointer == $past(word_pointer) - 4'h1)
      else $error("word pointer decrement failed");
   a_call_push: assert property (@(posedge sys_clk) disable iff (rst)
      (!clearing && op == MIO_CALL) |=> call_latch && ret_pc[0] == $past(instruction_pointer) + 6'h01)
      else $error("call did not save return address");
   a_subroutine_return_pop: assert property (@(posedge sys_clk) disable iff (rst)
      (!clearing && op == MIO_SUBROUTINE_RETURN) |=> instruction_pointer == $past(ret_pc[0]))
      else $error("return did not restore address");
   a_br_page: assert property (@(posedge sys_clk) disable iff (rst)
      (!clearing && op == MIO_BR) |=> page_address == $past(page_buffer))
      else $error("branch did not load page from buffer");
endmodule

// ===== mio_keypad.sv
// Keypad matrix model that answers on the scan inputs
`timescale 1ns/1ps
module mio_keypad #(
   parameter int R_COUNT = 11,
   parameter int STROBE = 0
) (
   input wire logic [R_COUNT-1:0] r_out,
   input wire logic in_clear,
   input wire logic [3:0] keys,
   output logic [3:0] scan_in
);
   // scan lines low unless strobed
   // Unstrobed lines fall to their pull-downs; keys are held off while clearing
   always_comb begin
      if (in_clear) begin
         scan_in = 4'h0;
      end else if (r_out[STROBE]) begin
         scan_in = keys;
      end else begin
         scan_in = 4'h0;
      end
   end
endmodule

// ===== tb.sv
// Self-checking bench for the I/O, data-memory and clear block
`timescale 1ns/1ps
module tb;
   import mio_pkg::*;
   function automatic logic [255:0] mk_tab();
      logic [255:0] t;
      for (int i = 0; i < 32; i++) begin
         t[i*8 +: 8] = 8'(i * 37 + 5);
      end
      return t;
   endfunction
   localparam logic [255:0] TAB = mk_tab();
   logic sys_clk = 1'b0;
   logic rst = 1'b1;
   logic status_latch = 1'b0;
   logic clear_pin = 1'b0;
   logic port_select = 1'b0;
   logic hold_mode_pin = 1'b0;
   mio_op_t op = MIO_NOP;
   logic [3:0] op_const = 4'h0;
   logic [3:0] acc_in = 4'h0;
   logic [3:0] aux_in = 4'h0;
   logic [3:0] keys = 4'h0;
   logic [3:0] scan_in, word_pointer, mem_word, acc_load, page_address, page_buffer;
   logic [2:0] file_select;
   logic [10:0] r_out;
   logic [7:0] par_out;
   logic [5:0] instruction_pointer;
   logic [1:0] chapter_buffer;
   logic acc_load_valid, status_out, call_latch, in_clear;
   int err_count = 0;
   int total_checks = 0;

   always #20 sys_clk = ~sys_clk;

   mio_core #(.R_COUNT(11), .PLA_TABLE(TAB)) DUT (.sys_clk(sys_clk), .rst(rst), .op(op),
      .op_const(op_const), .acc_in(acc_in), .status_latch(status_latch),
      .clear_pin(clear_pin), .scan_in(scan_in), .aux_in(aux_in), .port_select(port_select),
      .hold_mode_pin(hold_mode_pin), .word_pointer(word_pointer), .file_select(file_select),
      .mem_word(mem_word), .acc_load(acc_load), .acc_load_valid(acc_load_valid),
      .status_out(status_out), .r_out(r_out), .par_out(par_out),
      .instruction_pointer(instruction_pointer), .page_address(page_address),
      .page_buffer(page_buffer), .chapter_buffer(chapter_buffer), .call_latch(call_latch),
      .in_clear(in_clear));
   mio_keypad #(.R_COUNT(11)) keypad (.r_out(r_out), .in_clear(in_clear), .keys(keys),
      .scan_in(scan_in));

   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("unexpected %s: expected %h seen %h", name, exp, seen);
      end
   endtask
   // One op per call, with an idle cycle after it so op is never driven twice at one time
   task automatic do_op(input mio_op_t o, input logic [3:0] c);
      @(posedge sys_clk);
      #1 op = o;
      op_const = c;
      @(posedge sys_clk);
      #1 op = MIO_NOP;
   endtask
   task automatic wait_cyc(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask
   task automatic test_done();
      $display("checks %0d errors %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_reset();
      chk("in_clear", 16'(in_clear), 16'h0001);
      chk("ip", 16'(instruction_pointer), 16'h0000);
      chk("page", 16'({page_address, page_buffer}), 16'h00FF);
      chk("call", 16'(call_latch), 16'h0000);
      chk("r_out", 16'(r_out), 16'h0000);
      chk("par_out", 16'(par_out), 16'(TAB[7:0]));
   endtask
   task automatic t_ram();
      do_op(MIO_LDX, 4'h0);
      do_op(MIO_TCY, 4'h5);
      acc_in = 4'h3;
      do_op(MIO_TAM, 4'h0);
      do_op(MIO_LDX, 4'h7);
      acc_in = 4'hC;
      do_op(MIO_TAM, 4'h0);
      do_op(MIO_COMX, 4'h0);
      chk("file", 16'(file_select), 16'h0003);
      do_op(MIO_TCM, 4'hA);
      chk("tcm", 16'(word_pointer), 16'h0006);
      do_op(MIO_TCY, 4'h5);
      do_op(MIO_LDX, 4'h0);
      do_op(MIO_TMA, 4'h0);
      chk("acc", 16'({acc_load_valid, acc_load}), 16'h0013);
      chk("mem", 16'(mem_word), 16'h0003);
      do_op(MIO_LDX, 4'h7);
      do_op(MIO_TMA, 4'h0);
      chk("acc", 16'(acc_load), 16'h000C);
      do_op(MIO_COMX, 4'h0);
      do_op(MIO_TMY, 4'h0);
      chk("wp", 16'(word_pointer), 16'h000A);
      acc_in = 4'hF;
      do_op(MIO_TAY, 4'h0);
      do_op(MIO_IYC, 4'h0);
      chk("iyc", 16'({status_out, word_pointer}), 16'h0010);
      do_op(MIO_DYN, 4'h0);
      chk("dyn", 16'({status_out, word_pointer}), 16'h000F);
      do_op(MIO_YNEC, 4'hF);
      chk("ynec", 16'(status_out), 16'h0000);
      do_op(MIO_YNEC, 4'h4);
      chk("ynec", 16'(status_out), 16'h0001);
   endtask
   task automatic t_bits();
      do_op(MIO_LDX, 4'h2);
      for (int b = 0; b < 4; b++) begin
         do_op(MIO_TCY, 4'h4);
         do_op(MIO_TCM, 4'h0);
         do_op(MIO_TCY, 4'h4);
         do_op(MIO_SBIT, 4'(b));
         do_op(MIO_TBIT, 4'(b));
         chk("tbit", 16'(status_out), 16'h0001);
         do_op(MIO_TMA, 4'h0);
         chk("sbit", 16'(acc_load), 16'(1 << b));
         do_op(MIO_RBIT, 4'(b));
         do_op(MIO_TBIT, 4'(b));
         chk("rbit", 16'(status_out), 16'h0000);
      end
   endtask
   task automatic t_input();
      do_op(MIO_TCY, 4'h0);
      do_op(MIO_SETR, 4'h0);
      keys = 4'hE;
      wait_cyc(3);
      do_op(MIO_TKA, 4'h0);
      chk("scan", 16'(acc_load), 16'h000E);
      do_op(MIO_KNEZ, 4'h0);
      chk("knez", 16'(status_out), 16'h0001);
      keys = 4'h0;
      wait_cyc(3);
      do_op(MIO_KNEZ, 4'h0);
      chk("knez", 16'(status_out), 16'h0000);
      port_select = 1'b1;
      aux_in = 4'hA;
      wait_cyc(3);
      do_op(MIO_TKA, 4'h0);
      chk("aux", 16'(acc_load), 16'h000A);
      hold_mode_pin = 1'b1;
      aux_in = 4'h1;
      wait_cyc(3);
      aux_in = 4'h0;
      wait_cyc(3);
      do_op(MIO_TKA, 4'h0);
      chk("sense", 16'(acc_load), 16'h0001);
      hold_mode_pin = 1'b0;
      wait_cyc(3);
      do_op(MIO_TKA, 4'h0);
      chk("pass", 16'(acc_load), 16'h0000);
      port_select = 1'b0;
   endtask
   task automatic t_out();
      do_op(MIO_LDX, 4'h7);
      do_op(MIO_TCY, 4'hA);
      do_op(MIO_SETR, 4'h0);
      chk("r_out", 16'(r_out), 16'h0401);
      do_op(MIO_TCY, 4'hB);
      do_op(MIO_SETR, 4'h0);
      chk("r_out", 16'(r_out), 16'h0401);
      do_op(MIO_TCY, 4'h0);
      do_op(MIO_RSTR, 4'h0);
      chk("r_out", 16'(r_out), 16'h0400);
      for (int s = 0; s < 2; s++) begin
         status_latch = 1'(s);
         acc_in = 4'h3;
         do_op(MIO_TDO, 4'h0);
         wait_cyc(1);
         chk("par_out", 16'(par_out), 16'(TAB[(s * 16 + 3) * 8 +: 8]));
      end
      do_op(MIO_LDP, 4'h6);
      chk("pbuf", 16'(page_buffer), 16'h0006);
      do_op(MIO_TPC, 4'h0);
      chk("chap", 16'(chapter_buffer), 16'h0002);
   endtask
   task automatic t_stack();
      do_op(MIO_LDP, 4'h5);
      do_op(MIO_CALL, 4'h9);
      chk("call", 16'({call_latch, page_address, instruction_pointer}), 16'h0549);
      do_op(MIO_STEP, 4'h0);
      do_op(MIO_LDP, 4'h3);
      do_op(MIO_CALL, 4'h2);
      do_op(MIO_SUBROUTINE_RETURN, 4'h0);
      chk("subroutine_return", 16'({call_latch, page_address, instruction_pointer}), 16'h014B);
      chk("pbuf", 16'(page_buffer), 16'h0005);
      do_op(MIO_SUBROUTINE_RETURN, 4'h0);
      chk("subroutine_return", 16'({call_latch, page_address, instruction_pointer}), 16'h03C1);
      chk("chap", 16'(chapter_buffer), 16'h0000);
      do_op(MIO_LDP, 4'h7);
      do_op(MIO_BR, 4'h3);
      chk("br", 16'({call_latch, page_address, instruction_pointer}), 16'h01C3);
   endtask
   task automatic t_clear();
      do_op(MIO_TCY, 4'h5);
      clear_pin = 1'b1;
      wait_cyc(4);
      do_op(MIO_TCY, 4'h3);
      chk("wp", 16'(word_pointer), 16'h0005);
      t_reset();
      clear_pin = 1'b0;
      wait_cyc(4);
      chk("in_clear", 16'(in_clear), 16'h0000);
      do_op(MIO_TCY, 4'h3);
      chk("wp", 16'(word_pointer), 16'h0003);
   endtask

   initial begin
      #(40 * 4000);
      err_count++;
      test_done();
   end
   initial begin
      // power-up clear held before any op
      wait_cyc(2);
      t_reset();
      rst = 1'b0;
      wait_cyc(4);
      t_ram();
      t_bits();
      t_input();
      t_out();
      t_stack();
      t_clear();
      test_done();
   end
endmodule
